// file: design/sic_core.sv
/*
  Safety input conditioning: debounce filters, polarity, dual digital
  pairs with discrepancy check, analog channel voting, Boolean
  variables with single-writer ownership and default output values.
  Assumes field inputs synchronous to clock, and an APB master.
*/
// The APB register port and the address map are this design's own decisions.
// Behaviour
// - any raw edge starts the filter timer; further edges restart it
// - filtered output holds old value until timer expires without edge
// - filter time zero bypasses the debounce filter
// - program start clears filters; high inputs read false for one filter time
// - plain inputs suppress pulses up to filter time minus 15 us; here up to the whole filter time
// - test-pulse inputs suppress up to filter time minus pulses, constants, 43 us; here all inputs up to the whole filter time
// - dual pair is complementary when even-channel setting on, else equivalent
// - dual configuration carries true value, discrepancy, filter, complementary
// - four analog channels, each usable alone as a single monitor
// - one-of-two voting only on pairs 0/1 and 2/3; even reserves odd
// - two-of-three voting only led by channel 0; reserves 1 and 2
// - dual configurations expose only the even lead channel
// - at most 24 Boolean variables for machines and scan port
// - each variable has one writing machine; all machines may read it
// - outputs, variables and lamp take their default when not driven; variables here load it only at program start
// - per-channel polarity decides which pin level reads as true
// - dual pair comparison deferred by discrepancy time after a change
`timescale 1ns/10ps
`default_nettype none
module sic_core #(
  parameter int NDI = sic_pkg::NUM_DI
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NDI-1:0] di_raw,
  input wire logic analog_in_ch0,
  input wire logic analog_in_ch1,
  input wire logic analog_in_ch2,
  input wire logic analog_in_ch3,
  input wire logic [sic_pkg::SM_ID_W-1:0] sm_var_id,
  input wire logic [sic_pkg::NUM_VAR-1:0] sm_var_we,
  input wire logic [sic_pkg::NUM_VAR-1:0] sm_var_wdata,
  input wire logic [sic_pkg::NUM_DO-1:0] sm_do_drive,
  input wire logic [sic_pkg::NUM_DO-1:0] sm_do_val,
  input wire logic sm_lamp_drive,
  input wire logic sm_lamp_val,
  output logic [NDI-1:0] di_true,
  output logic [NDI/2-1:0] disc_fault,
  output logic [sic_pkg::NUM_AI-1:0] ai_vote,
  output logic [sic_pkg::NUM_AI-1:0] ai_reserved,
  output logic [sic_pkg::NUM_VAR-1:0] var_value,
  output logic [sic_pkg::NUM_DO-1:0] do_out,
  output logic user_indicator_lamp,
  output logic prog_running
);

  // ****************************************
  // register bus
  // ****************************************
  logic run_q;
  logic [NDI-1:0] pol_q, dual_q, compl_q;
  logic [sic_pkg::TIME_W-1:0] filt_time_q, disc_time_q;
  logic [1:0] ai_ch0_q, ai_ch2_q;
  logic [sic_pkg::NUM_VAR-1:0] var_def_q;
  logic [sic_pkg::NUM_DO:0] out_def_q;
  logic [sic_pkg::SM_ID_W-1:0] owner_q [sic_pkg::NUM_VAR];
  logic wr, start;
  logic [NDI-1:0] even_mask;
  logic [sic_pkg::CNT_W-1:0] filt_lim, disc_lim;

  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  // settings steer timers only in cycles, so scale once here
  assign filt_lim = sic_pkg::CNT_W'(filt_time_q) * sic_pkg::CNT_W'(sic_pkg::CYC_PER_US);
  assign disc_lim = sic_pkg::CNT_W'(disc_time_q) * sic_pkg::CNT_W'(sic_pkg::CYC_PER_US);

  // pair settings live on even channels only
  always_comb begin
    for (int k = 0; k < NDI; k++) begin
      even_mask[k] = (k % 2) == 0;
    end
  end

  // configuration writes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 1'b0;
      pol_q <= '0;
      dual_q <= '0;
      compl_q <= '0;
      filt_time_q <= sic_pkg::FILT_TIME_RST;
      disc_time_q <= sic_pkg::DISC_TIME_RST;
      ai_ch0_q <= 2'h0;
      ai_ch2_q <= 2'h0;
      var_def_q <= '0;
      out_def_q <= '0;
      for (int v = 0; v < sic_pkg::NUM_VAR; v++) begin
        owner_q[v] <= '0;
      end
    end else if (wr) begin
      unique case (paddr)
        sic_pkg::OFS_CTRL: run_q <= pwdata[sic_pkg::CTRL_RUN_BIT];
        sic_pkg::OFS_DI_POL: pol_q <= pwdata[NDI-1:0];
        sic_pkg::OFS_DI_DUAL: dual_q <= pwdata[NDI-1:0] & even_mask;
        sic_pkg::OFS_DI_COMPL: compl_q <= pwdata[NDI-1:0] & even_mask;
        sic_pkg::OFS_FILT_TIME: filt_time_q <= pwdata[sic_pkg::TIME_W-1:0];
        sic_pkg::OFS_DISC_TIME: disc_time_q <= pwdata[sic_pkg::TIME_W-1:0];
        sic_pkg::OFS_AI_CFG: begin
          ai_ch0_q <= pwdata[sic_pkg::AI_CFG_CH0_LSB +: 2];
          ai_ch2_q <= pwdata[sic_pkg::AI_CFG_CH2_LSB +: 2];
        end
        sic_pkg::OFS_VAR_DEFAULT: var_def_q <= pwdata[sic_pkg::NUM_VAR-1:0];
        sic_pkg::OFS_OUT_DEFAULT: out_def_q <= pwdata[sic_pkg::NUM_DO:0];
        default: begin
          // owner words: eight 3-bit machine ids per word
          for (int w = 0; w < sic_pkg::NUM_VAR / sic_pkg::OWN_PER_WORD; w++) begin
            if (paddr == sic_pkg::OFS_VAR_OWNER0 + 12'(4 * w)) begin
              for (int f = 0; f < sic_pkg::OWN_PER_WORD; f++) begin
                owner_q[w * sic_pkg::OWN_PER_WORD + f] <= pwdata[f * sic_pkg::SM_ID_W +: sic_pkg::SM_ID_W];
              end
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // program start
  // ****************************************
  logic run_p;

  // rising edge of run starts the user program
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_p <= 1'b0;
    end else begin
      run_p <= run_q;
    end
  end
  assign start = run_q & ~run_p;
  assign prog_running = run_q;

  // ****************************************
  // debounce filters and polarity
  // ****************************************
  logic [NDI-1:0] raw_q, filt, tv;

  // one stage of history to see raw edges
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      raw_q <= '0;
    end else begin
      raw_q <= di_raw;
    end
  end

  // the filter adopts only after a full quiet time, so the longest
  // rejected pulse is the filter time less pipeline residue:
  // residue zero here, so plain inputs reject up to the whole filter time
  // test pulse residue handled by configured times
  for (genvar i = 0; i < NDI; i++) begin : g_di
    logic [sic_pkg::CNT_W-1:0] cnt_q;
    logic tmr_q, f_q;
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        cnt_q <= '0;
        tmr_q <= 1'b0;
        f_q <= 1'b0;
      end else if (start) begin
        cnt_q <= '0;
        tmr_q <= 1'b1;
        f_q <= 1'b0;
      end else if (filt_lim == '0) begin
        cnt_q <= '0;
        tmr_q <= 1'b0;
        f_q <= di_raw[i];
      end else if (di_raw[i] != raw_q[i]) begin
        cnt_q <= '0;
        tmr_q <= 1'b1;
      end else if (tmr_q) begin
        if (cnt_q == filt_lim - sic_pkg::CNT_W'(1)) begin
          tmr_q <= 1'b0;
          f_q <= raw_q[i];
        end else begin
          cnt_q <= cnt_q + sic_pkg::CNT_W'(1);
        end
      end
    end
    assign filt[i] = f_q;
    assign tv[i] = f_q ^ pol_q[i];
  end

  // odd partner of a dual pair is hidden from the machines
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      di_true <= '0;
    end else begin
      for (int k = 0; k < NDI; k++) begin
        di_true[k] <= tv[k] & ~((k % 2 == 1) && dual_q[k - k % 2]);
      end
    end
  end

  // ****************************************
  // dual pair discrepancy
  // ****************************************
  logic [NDI/2-1:0] fault_clr;
  logic [NDI-1:0] tv_p;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tv_p <= '0;
    end else begin
      tv_p <= tv;
    end
  end
  assign fault_clr = (wr && paddr == sic_pkg::OFS_DISC_FAULT) ? pwdata[NDI/2-1:0] : '0;

  for (genvar p = 0; p < NDI / 2; p++) begin : g_pair
    logic [sic_pkg::CNT_W-1:0] dcnt_q;
    logic dtmr_q, fl_q, chg, agree, expire;
    assign chg = (tv[2*p] != tv_p[2*p]) | (tv[2*p+1] != tv_p[2*p+1]);
    assign agree = compl_q[2*p] ? (tv[2*p] != tv[2*p+1]) : (tv[2*p] == tv[2*p+1]);
    assign expire = dtmr_q && !chg && dcnt_q >= disc_lim;
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        dcnt_q <= '0;
        dtmr_q <= 1'b0;
      end else if (!dual_q[2*p] || start || chg) begin
        dcnt_q <= '0;
        dtmr_q <= dual_q[2*p];
      end else if (expire) begin
        dtmr_q <= 1'b0;
      end else if (dtmr_q) begin
        dcnt_q <= dcnt_q + sic_pkg::CNT_W'(1);
      end
    end
    // sticky fault; a new fault beats a same-cycle clear
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        fl_q <= 1'b0;
      end else if (expire && !agree) begin
        fl_q <= 1'b1;
      end else if (fault_clr[p]) begin
        fl_q <= 1'b0;
      end
    end
    assign disc_fault[p] = fl_q;
  end

  // ****************************************
  // analog voting
  // ****************************************
  logic [sic_pkg::NUM_AI-1:0] ai;
  logic m0_dual, m0_tri, m2_dual;

  assign ai = {analog_in_ch3, analog_in_ch2, analog_in_ch1, analog_in_ch0};
  assign m0_dual = ai_ch0_q == sic_pkg::SIC_AI_DUAL;
  // triple only led by channel 0
  assign m0_tri = ai_ch0_q == sic_pkg::SIC_AI_TRIPLE;
  // channel 2 cannot lead a triple
  assign m2_dual = ai_ch2_q == sic_pkg::SIC_AI_DUAL && !m0_tri;

  // reserved channels read zero; illegal codes act as single
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ai_vote <= '0;
      ai_reserved <= '0;
    end else begin
      ai_vote <= ai;
      // channel 2 is only reserved by a triple; as a dual it is the lead
      ai_reserved <= {m2_dual, m0_tri, m0_dual | m0_tri, 1'b0};
      if (m0_tri) begin
        ai_vote[2:0] <= {2'b00, (ai[0] & ai[1]) | (ai[0] & ai[2]) | (ai[1] & ai[2])};
      end else if (m0_dual) begin
        ai_vote[1:0] <= {1'b0, ai[0] | ai[1]};
      end
      if (m2_dual) begin
        ai_vote[3:2] <= {1'b0, ai[2] | ai[3]};
      end
    end
  end

  // ****************************************
  // variables and default outputs
  // ****************************************
  // fixed pool of 24 variables
  logic [sic_pkg::NUM_VAR-1:0] var_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      var_q <= '0;
    end else if (start) begin
      var_q <= var_def_q;
    end else begin
      for (int v = 0; v < sic_pkg::NUM_VAR; v++) begin
        if (sm_var_we[v] && sm_var_id == owner_q[v]) begin
          var_q[v] <= sm_var_wdata[v];
        end
      end
    end
  end
  assign var_value = var_q;

  // undriven outputs and lamp show default
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      do_out <= '0;
      user_indicator_lamp <= 1'b0;
    end else begin
      do_out <= (sm_do_drive & sm_do_val) | (~sm_do_drive & out_def_q[sic_pkg::NUM_DO-1:0]);
      user_indicator_lamp <= sm_lamp_drive ? sm_lamp_val : out_def_q[sic_pkg::LAMP_DEF_BIT];
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // variables are read-only on the bus
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    unique case (paddr)
      sic_pkg::OFS_CTRL: prdata[0] = run_q;
      sic_pkg::OFS_DI_POL: prdata[NDI-1:0] = pol_q;
      sic_pkg::OFS_DI_DUAL: prdata[NDI-1:0] = dual_q;
      sic_pkg::OFS_DI_COMPL: prdata[NDI-1:0] = compl_q;
      sic_pkg::OFS_FILT_TIME: prdata[sic_pkg::TIME_W-1:0] = filt_time_q;
      sic_pkg::OFS_DISC_TIME: prdata[sic_pkg::TIME_W-1:0] = disc_time_q;
      sic_pkg::OFS_AI_CFG: prdata[3:0] = {ai_ch2_q, ai_ch0_q};
      sic_pkg::OFS_VAR_DEFAULT: prdata[sic_pkg::NUM_VAR-1:0] = var_def_q;
      sic_pkg::OFS_OUT_DEFAULT: prdata[sic_pkg::NUM_DO:0] = out_def_q;
      sic_pkg::OFS_STATUS: prdata[2*NDI-1:0] = {raw_q, filt};
      sic_pkg::OFS_DISC_FAULT: prdata[NDI/2-1:0] = disc_fault;
      sic_pkg::OFS_VAR_VALUE: prdata[sic_pkg::NUM_VAR-1:0] = var_q;
      sic_pkg::OFS_AI_VOTE: prdata[7:0] = {ai_reserved, ai_vote};
      default: begin
        pslverr = psel & penable;
        for (int w = 0; w < sic_pkg::NUM_VAR / sic_pkg::OWN_PER_WORD; w++) begin
          if (paddr == sic_pkg::OFS_VAR_OWNER0 + 12'(4 * w)) begin
            pslverr = 1'b0;
            for (int f = 0; f < sic_pkg::OWN_PER_WORD; f++) begin
              prdata[f * sic_pkg::SM_ID_W +: sic_pkg::SM_ID_W] = owner_q[w * sic_pkg::OWN_PER_WORD + f];
            end
          end
        end
      end
    endcase
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_edge0; di_raw[0] != raw_q[0] && !start && filt_lim != '0; endsequence
  sequence s_quiet0; di_raw[0] == raw_q[0] && !start; endsequence

  property p_edge_holds;
    s_edge0 |=> $stable(filt[0]);
  endproperty
  a_edge_holds: assert property (p_edge_holds) else $error("filter moved on a raw edge");

  property p_hold_until_expiry;
    s_edge0 ##1 s_quiet0 |=> $stable(filt[0]) || $past(filt_lim) < sic_pkg::CNT_W'(2) || $changed(filt_lim);
  endproperty
  a_hold_until_expiry: assert property (p_hold_until_expiry) else $error("filter changed early");

  property p_bypass;
    filt_lim == '0 && !start |=> filt[0] == $past(di_raw[0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("zero filter did not pass raw");

  property p_start_clears;
    start |=> filt == '0 ##1 (filt_lim < sic_pkg::CNT_W'(2) || filt == '0);
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("filter not cleared at start");

  property p_odd_hidden;
    dual_q[6] |=> !di_true[7];
  endproperty
  a_odd_hidden: assert property (p_odd_hidden) else $error("odd partner visible");

  property p_triple_vote;
    m0_tri |=> ai_vote[0] == $past((ai[0] & ai[1]) | (ai[0] & ai[2]) | (ai[1] & ai[2])) && ai_vote[2:1] == 2'b00;
  endproperty
  a_triple_vote: assert property (p_triple_vote) else $error("two of three vote wrong");

  property p_owner_only;
    sm_var_we[0] && sm_var_id != owner_q[0] && !start |=> $stable(var_q[0]);
  endproperty
  a_owner_only: assert property (p_owner_only) else $error("foreign machine wrote variable");

  property p_default_out;
    !sm_do_drive[0] |=> do_out[0] == $past(out_def_q[0]);
  endproperty
  a_default_out: assert property (p_default_out) else $error("undriven output not default");

  property p_polarity;
    !dual_q[0] |=> di_true[0] == $past(filt[0] ^ pol_q[0]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not applied");

  property p_disc_wait;
    $rose(disc_fault[3]) |-> $past(g_pair[3].dtmr_q) && $past(g_pair[3].dcnt_q) >= $past(disc_lim);
  endproperty
  a_disc_wait: assert property (p_disc_wait) else $error("fault before discrepancy time");

endmodule
`default_nettype wire

// file: design/sic_pkg.sv
/*
  Constants for the safety input conditioning block: register map,
  field positions, reset values, channel counts and timing.
  Assumes a 50 MHz module clock and a 32-bit APB register bus.
*/
package sic_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
  localparam int FILT_RESIDUE_US = 15;
  localparam int TP_RESIDUE_US = 43;
  localparam int TIME_W = 16;
  localparam int CNT_W = 22;

  // ****************************************
  // channel counts
  // ****************************************
  localparam int NUM_DI = 8;
  localparam int NUM_DO = 8;
  localparam int NUM_AI = 4;
  localparam int NUM_VAR = 24;
  localparam int SM_ID_W = 3;
  localparam int OWN_PER_WORD = 8;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DI_POL = 12'h004;
  localparam logic [11:0] OFS_DI_DUAL = 12'h008;
  localparam logic [11:0] OFS_DI_COMPL = 12'h00C;
  localparam logic [11:0] OFS_FILT_TIME = 12'h010;
  localparam logic [11:0] OFS_DISC_TIME = 12'h014;
  localparam logic [11:0] OFS_AI_CFG = 12'h018;
  localparam logic [11:0] OFS_VAR_DEFAULT = 12'h01C;
  localparam logic [11:0] OFS_VAR_OWNER0 = 12'h020;
  localparam logic [11:0] OFS_OUT_DEFAULT = 12'h02C;
  localparam logic [11:0] OFS_STATUS = 12'h030;
  localparam logic [11:0] OFS_DISC_FAULT = 12'h034;
  localparam logic [11:0] OFS_VAR_VALUE = 12'h038;
  localparam logic [11:0] OFS_AI_VOTE = 12'h03C;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int AI_CFG_CH0_LSB = 0;
  localparam int AI_CFG_CH2_LSB = 2;
  localparam int LAMP_DEF_BIT = 8;
  localparam logic [TIME_W-1:0] FILT_TIME_RST = 16'h0000;
  localparam logic [TIME_W-1:0] DISC_TIME_RST = 16'h0000;

  typedef enum logic [1:0] {
    SIC_AI_SINGLE,
    SIC_AI_DUAL,
    SIC_AI_TRIPLE
  } sic_ai_mode_t;

endpackage

// file: test/sic_core_bench.sv
/*
  Self-checking bench for sic_core: APB read/write task, field model,
  directed sequences with expected values.
  Assumes sic_pkg, sic_core and sic_field_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("Error %0t: got %h want %h", $time, a, b); end end
module sic_core_bench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] want_di = 8'h00;
  logic [7:0] bounce_len = 8'h00;
  logic [3:0] want_ai = 4'h0;
  logic [7:0] di_raw;
  logic [3:0] ai_level;
  logic [2:0] sm_var_id = 3'h0;
  logic [23:0] sm_var_we = 24'h000000;
  logic [23:0] sm_var_wdata = 24'h000000;
  logic [7:0] sm_do_drive = 8'h00;
  logic [7:0] sm_do_val = 8'h00;
  logic sm_lamp_drive = 1'b0;
  logic sm_lamp_val = 1'b0;
  logic [7:0] di_true;
  logic [3:0] disc_fault;
  logic [3:0] ai_vote;
  logic [3:0] ai_reserved;
  logic [23:0] var_value;
  logic [7:0] do_out;
  logic user_indicator_lamp;
  logic prog_running;
  logic [31:0] rq;
  logic re;
  logic seen;
  int err_count = 0;
  int checks = 0;
  // analog table: mode word, demands, expected {reserved, vote}
  logic [3:0] t_cfg [5] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h4};
  logic [3:0] t_ai [5] = '{4'hA, 4'h2, 4'h3, 4'h9, 4'h8};
  logic [7:0] t_exp [5] = '{8'h0A, 8'h21, 8'h61, 8'h68, 8'h84};

  // ****************************************
  // clock, reset, instances
  // ****************************************
  initial forever #10 clock = ~clock;
  sic_core sic_core_inst (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .di_raw(di_raw),
    .analog_in_ch0(ai_level[0]), .analog_in_ch1(ai_level[1]), .analog_in_ch2(ai_level[2]),
    .analog_in_ch3(ai_level[3]), .sm_var_id(sm_var_id), .sm_var_we(sm_var_we), .sm_var_wdata(sm_var_wdata),
    .sm_do_drive(sm_do_drive), .sm_do_val(sm_do_val), .sm_lamp_drive(sm_lamp_drive), .sm_lamp_val(sm_lamp_val),
    .di_true(di_true), .disc_fault(disc_fault), .ai_vote(ai_vote), .ai_reserved(ai_reserved),
    .var_value(var_value), .do_out(do_out), .user_indicator_lamp(user_indicator_lamp),
    .prog_running(prog_running));
  sic_field_model sic_field_model_inst (.clock(clock), .want_di(want_di), .bounce_len(bounce_len),
    .want_ai(want_ai), .di_raw(di_raw), .ai_level(ai_level));

  // ****************************************
  // tasks
  // ****************************************
  // one APB transfer; the leading edge keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task end_of_test;
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog well beyond the several hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    end_of_test;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    tick(5);
    sys_rst <= 1'b0;
    apb(1'b0, sic_pkg::OFS_FILT_TIME, 32'h0);
    `CHK(rq, 32'h00000000)
    apb(1'b0, 12'hFFC, 32'h0);
    `CHK({re, rq}, {1'b1, 32'h00000000})
    apb(1'b1, sic_pkg::OFS_FILT_TIME, 32'h1);
    apb(1'b1, sic_pkg::OFS_VAR_DEFAULT, 32'h00A5A5);
    apb(1'b1, sic_pkg::OFS_OUT_DEFAULT, 32'h1F0);
    want_di <= 8'h01;
    tick(3);
    apb(1'b1, sic_pkg::OFS_CTRL, 32'h1);
    // input high at start stays false for one filter time
    tick(10);
    `CHK(di_true[0], 1'b0)
    `CHK(prog_running, 1'b1)
    tick(60);
    `CHK(di_true[0], 1'b1)
    `CHK(var_value, 24'h00A5A5)
    `CHK({user_indicator_lamp, do_out}, 9'h1F0)
    // short pulse is swallowed
    want_di <= 8'h05;
    tick(30);
    want_di <= 8'h01;
    seen = 1'b0;
    repeat (100) begin
      @(posedge clock);
      seen = seen | di_true[2];
    end
    `CHK(seen, 1'b0)
    // chatter keeps restarting the timer
    bounce_len <= 8'd20;
    want_di <= 8'h09;
    tick(60);
    `CHK(di_true[3], 1'b0)
    tick(35);
    `CHK(di_true[3], 1'b1)
    bounce_len <= 8'd0;
    apb(1'b1, sic_pkg::OFS_FILT_TIME, 32'h0);
    want_di <= 8'h19;
    tick(4);
    `CHK(di_true[4], 1'b1)
    // raw and filtered agree once the filter is bypassed
    apb(1'b0, sic_pkg::OFS_STATUS, 32'h0);
    `CHK(rq[15:0], 16'h1919)
    apb(1'b1, sic_pkg::OFS_DI_POL, 32'h20);
    tick(4);
    `CHK(di_true[5], 1'b1)
    // dual pair on channels 6 and 7
    apb(1'b1, sic_pkg::OFS_DISC_TIME, 32'h1);
    want_di <= 8'hD9;
    apb(1'b1, sic_pkg::OFS_DI_DUAL, 32'h40);
    tick(80);
    `CHK(di_true[7:6], 2'b01)
    `CHK(disc_fault[3], 1'b0)
    want_di <= 8'h59;
    tick(20);
    `CHK(disc_fault[3], 1'b0)
    tick(60);
    `CHK(disc_fault[3], 1'b1)
    apb(1'b1, sic_pkg::OFS_DI_COMPL, 32'h40);
    apb(1'b1, sic_pkg::OFS_DISC_FAULT, 32'h8);
    // differing pair would fault if still judged as equivalent
    want_di <= 8'h99;
    tick(80);
    apb(1'b0, sic_pkg::OFS_DISC_FAULT, 32'h0);
    `CHK(rq[3:0], 4'h0)
    apb(1'b0, sic_pkg::OFS_DI_DUAL, 32'h0);
    `CHK(rq[7:0], 8'h40)
    // analog modes and voting
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, sic_pkg::OFS_AI_CFG, {28'h0, t_cfg[i]});
      want_ai <= t_ai[i];
      tick(4);
      `CHK({ai_reserved, ai_vote}, t_exp[i])
      apb(1'b0, sic_pkg::OFS_AI_VOTE, 32'h0);
      `CHK(rq[7:0], t_exp[i])
    end
    // variables: only the owner writes, bus cannot
    apb(1'b1, sic_pkg::OFS_VAR_OWNER0, 32'h3);
    @(posedge clock);
    sm_var_id <= 3'h2;
    sm_var_we <= 24'h000001;
    @(posedge clock);
    sm_var_id <= 3'h3;
    @(posedge clock);
    sm_var_id <= 3'h0;
    sm_var_we <= 24'h800000;
    sm_var_wdata <= 24'h800000;
    @(posedge clock);
    sm_var_we <= 24'h000000;
    tick(2);
    `CHK(var_value, 24'h80A5A4)
    apb(1'b1, sic_pkg::OFS_VAR_VALUE, 32'h0);
    apb(1'b0, sic_pkg::OFS_VAR_VALUE, 32'h0);
    `CHK(rq[23:0], 24'h80A5A4)
    // driven outputs override the defaults
    sm_do_drive <= 8'h0F;
    sm_do_val <= 8'h05;
    sm_lamp_drive <= 1'b1;
    tick(3);
    `CHK({user_indicator_lamp, do_out}, 9'h0F5)
    end_of_test;
  end
endmodule
`default_nettype wire

// file: test/sic_field_model.sv
/*
  Field side model: contact switches on the digital inputs, which bounce
  for a set number of cycles before settling, and analog demand levels.
  Assumes the bench changes the wanted levels just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module sic_field_model (
  input wire logic clock,
  input wire logic [7:0] want_di,
  input wire logic [7:0] bounce_len,
  input wire logic [3:0] want_ai,
  output logic [7:0] di_raw,
  output logic [3:0] ai_level
);
  // ****************************************
  // contact bounce
  // ****************************************
  logic [7:0] level_q = 8'h00;
  logic [7:0] cnt_q = 8'h00;
  initial di_raw = 8'h00;
  initial ai_level = 4'h0;
  // changed contacts chatter, then settle; a real switch gives no clean edge
  always @(posedge clock) begin
    ai_level <= want_ai;
    if (want_di != level_q) begin
      if (cnt_q < bounce_len) begin
        cnt_q <= cnt_q + 8'h01;
        di_raw <= di_raw ^ (want_di ^ level_q);
      end else begin
        cnt_q <= 8'h00;
        level_q <= want_di;
        di_raw <= want_di;
      end
    end
  end
endmodule
`default_nettype wire
